// ===== verilog/cpsr_pkg.sv
// Constants for the copper shadow/status register group.
// Assumes a register access port with 16-bit address and data.
package cpsr_pkg;
   // ----------------------------------------
   // Addresses and page codes
   // ----------------------------------------
   localparam logic [15:0] ADDR_PAGE = 16'hfffc;
   localparam logic [15:0] ADDR_SEED = 16'hfffd;
   localparam logic [4:0] PAGE_SPARE = 5'h04;
   localparam logic [4:0] PAGE_APD = 5'h0a;
   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int WE_BIT = 15;
   localparam int SEL_LSB = 10;
   localparam int RETRY_LSB = 2;
   localparam int ED_BIT = 1;
   localparam int APD_EN_BIT = 5;
   localparam int SLEEP_SEL_BIT = 4;
   localparam int WAKE_LSB = 0;
   localparam int SEED_MATCH_BIT = 14;
   localparam int RSV_HI_LSB = 6;
   // ----------------------------------------
   // Reset values
   // ----------------------------------------
   localparam logic [9:0] SPARE_RST = 10'h000;
   localparam logic [9:0] APD_RST = 10'h001;
   localparam logic [10:0] SEED_RST = 11'h000;
   localparam logic [3:0] RETRY_BASE = 4'h2;
   localparam logic [3:0] RETRY_OFF = 4'h0;
   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CLK_PERIOD_NS = 10;
   localparam int WAKE_UNIT_MS = 84;
   localparam int SLEEP_SHORT_MS = 2700;
   localparam int SLEEP_LONG_MS = 5400;
   localparam int NS_PER_MS = 1000000;
   localparam int WAKE_UNIT_CYC = WAKE_UNIT_MS * (NS_PER_MS / CLK_PERIOD_NS);
   localparam int SLEEP_SHORT_CYC = SLEEP_SHORT_MS * (NS_PER_MS / CLK_PERIOD_NS);
   localparam int SLEEP_LONG_CYC = SLEEP_LONG_MS * (NS_PER_MS / CLK_PERIOD_NS);
   localparam int TMR_W = 30;
   // ----------------------------------------
   // Auto power-down states
   // ----------------------------------------
   typedef enum logic [1:0] {
      CPSR_ACTIVE = 2'b00,
      CPSR_SLEEP = 2'b01,
      CPSR_WAKE = 2'b11
   } cpsr_apd_e;
endpackage : cpsr_pkg

// ===== verilog/cpsr_regs.sv
// Copper shadow page, power-down and seed/status register group.
// Assumes the management access port is already decoded from MDIO frames,
// and that the negotiation engine gives one-cycle event pulses.
//
// Operation
// - Page data written only when bit15 set
// - Write selector first, then read returns page
// - Code 00100 selects spare page, reset code
// - Retry code 000..111 means 2..9 attempts
// - Retry limit used only in downgrade mode
// - Bit1 routes energy detect to interrupt pin
// - Code 01010 selects power-down page
// - Bit5 enables auto power-down, resets 0
// - Bit4 picks 5.4s or 2.7s sleep
// - Wake time is count times 84 ms
// - Seed address bit15 selects status register
// - Seed match bit14 latched high
// - Bit13 shows partner repeater or end station
// - Bits12,11 show partner manual master config
// - Bits10:0 return local seed, reset zero
// - Write to selected register takes one cycle
// - Bit14 shows gigabit advertising suppressed
// - Bit13 shows 100BASE-TX advertising suppressed
// - Bit12 latches speed downgrade event
// - Bits11:8 latch negotiated mode results
// - Bits5:4 latch gigabit result without link
// - Bits3:2 latch 100BASE-TX result without link
// - Negotiation disable/restart clears latched status bits 12, 11:8 and 5:2
`timescale 1ns/100ps
module cpsr_regs #(
   parameter int WAKE_UNIT_CYC = cpsr_pkg::WAKE_UNIT_CYC,
   parameter int SLEEP_SHORT_CYC = cpsr_pkg::SLEEP_SHORT_CYC,
   parameter int SLEEP_LONG_CYC = cpsr_pkg::SLEEP_LONG_CYC
) (
   input wire logic i_ref_clk,
   input wire logic i_rstn,
   input wire logic [15:0] i_reg_addr,
   input wire logic [15:0] i_reg_wdata,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   output logic [15:0] o_reg_rdata,
   output logic o_reg_rvalid,
   input wire logic i_downgrade_enable,
   input wire logic i_energy_detect,
   input wire logic i_irq_request,
   input wire logic [10:0] i_local_seed,
   input wire logic i_local_seed_valid,
   input wire logic i_seed_match,
   input wire logic i_partner_repeater,
   input wire logic i_partner_master,
   input wire logic i_partner_manual_en,
   input wire logic i_gig_adv_off,
   input wire logic i_tx100_adv_off,
   input wire logic i_downgrade_event,
   input wire logic i_mode_result_valid,
   input wire logic i_mode_result_no_link,
   input wire logic [1:0] i_negotiated_mode_result,
   input wire logic i_an_clear,
   output logic [3:0] o_downgrade_attempts,
   output logic o_interrupt_output_pin,
   output logic o_apd_sleep,
   output logic o_apd_wake
);
   // ----------------------------------------
   // Parameter checks
   // ----------------------------------------
   if (WAKE_UNIT_CYC < 1 || SLEEP_SHORT_CYC < 1 || SLEEP_LONG_CYC < 1) begin : g_chk_min
      $error("cpsr_regs: timer counts must be at least one cycle");
   end
   if (longint'(WAKE_UNIT_CYC) * 15 >= (longint'(1) << cpsr_pkg::TMR_W) ||
       SLEEP_LONG_CYC >= (1 << cpsr_pkg::TMR_W)) begin : g_chk_max
      $error("cpsr_regs: timer counts exceed counter width");
   end

   // ----------------------------------------
   // Access decode
   // ----------------------------------------
   logic page_wr;
   logic page_rd;
   logic seed_wr;
   logic seed_rd;
   logic [4:0] wr_sel;
   assign page_wr = i_reg_wr && (i_reg_addr == cpsr_pkg::ADDR_PAGE);
   assign page_rd = i_reg_rd && (i_reg_addr == cpsr_pkg::ADDR_PAGE);
   assign seed_wr = i_reg_wr && (i_reg_addr == cpsr_pkg::ADDR_SEED);
   assign seed_rd = i_reg_rd && (i_reg_addr == cpsr_pkg::ADDR_SEED);
   assign wr_sel = i_reg_wdata[cpsr_pkg::SEL_LSB +: 5];

   // ----------------------------------------
   // Multiplexed page address
   // ----------------------------------------
   logic [4:0] sel_reg;
   logic [9:0] spare_reg;
   logic [9:0] apd_reg;

   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         sel_reg <= cpsr_pkg::PAGE_SPARE;
      end else if (page_wr) begin
         sel_reg <= wr_sel;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         spare_reg <= cpsr_pkg::SPARE_RST;
         apd_reg <= cpsr_pkg::APD_RST;
      end else if (page_wr && i_reg_wdata[cpsr_pkg::WE_BIT]) begin
         if (wr_sel == cpsr_pkg::PAGE_SPARE) begin
            spare_reg <= i_reg_wdata[9:0];
         end else if (wr_sel == cpsr_pkg::PAGE_APD) begin
            apd_reg <= i_reg_wdata[9:0];
         end
      end
   end

   // Unassigned page codes read back zero data
   logic [9:0] page_data;
   always_comb begin
      if (sel_reg == cpsr_pkg::PAGE_SPARE) begin
         page_data = spare_reg;
      end else if (sel_reg == cpsr_pkg::PAGE_APD) begin
         page_data = apd_reg;
      end else begin
         page_data = '0;
      end
   end

   // ----------------------------------------
   // Seed / status address
   // ----------------------------------------
   logic shadow_reg;
   logic [10:0] seed_reg;
   logic [1:0] rsv_hi_reg;
   logic [1:0] rsv_lo_reg;

   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         shadow_reg <= 1'b0;
      end else if (seed_wr) begin
         shadow_reg <= i_reg_wdata[cpsr_pkg::WE_BIT];
      end
   end

   // Software writes win over a fresh seed in the same cycle
   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         seed_reg <= cpsr_pkg::SEED_RST;
      end else if (seed_wr && !i_reg_wdata[cpsr_pkg::WE_BIT]) begin
         seed_reg <= i_reg_wdata[10:0];
      end else if (i_local_seed_valid) begin
         seed_reg <= i_local_seed;
      end
   end

   // Reserved status bits just hold what software wrote
   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         rsv_hi_reg <= 2'b00;
         rsv_lo_reg <= 2'b00;
      end else if (seed_wr && i_reg_wdata[cpsr_pkg::WE_BIT]) begin
         rsv_hi_reg <= i_reg_wdata[cpsr_pkg::RSV_HI_LSB +: 2];
         rsv_lo_reg <= i_reg_wdata[1:0];
      end
   end

   // ----------------------------------------
   // Latched-high bits
   // ----------------------------------------
   // Index 0 seed match, 1 downgrade, 5:2 result, 9:6 result without link
   localparam int LH_N = 10;
   logic [LH_N-1:0] lh_set;
   logic [LH_N-1:0] lh_clr;
   logic [LH_N-1:0] lh_reg;
   logic [3:0] mode_onehot;
   logic stat_rd;
   logic seed_only_rd;

   assign mode_onehot = 4'b0001 << i_negotiated_mode_result;
   assign stat_rd = seed_rd && shadow_reg;
   assign seed_only_rd = seed_rd && !shadow_reg;
   assign lh_set = {i_mode_result_no_link ? mode_onehot : 4'h0,
                    i_mode_result_valid ? mode_onehot : 4'h0,
                    i_downgrade_event,
                    i_seed_match};
   assign lh_clr = {{(LH_N-1){stat_rd || i_an_clear}}, seed_only_rd};

   for (genvar b = 0; b < LH_N; b++) begin : g_lh
      // A new event in the clearing cycle survives
      always_ff @(posedge i_ref_clk or negedge i_rstn) begin
         if (!i_rstn) begin
            lh_reg[b] <= 1'b0;
         end else if (lh_set[b]) begin
            lh_reg[b] <= 1'b1;
         end else if (lh_clr[b]) begin
            lh_reg[b] <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // Read data
   // ----------------------------------------
   logic [15:0] seed_word;
   logic [15:0] stat_word;
   assign seed_word = {shadow_reg, lh_reg[0], i_partner_repeater, i_partner_master,
                       i_partner_manual_en, seed_reg};
   assign stat_word = {shadow_reg, i_gig_adv_off, i_tx100_adv_off, lh_reg[1],
                       lh_reg[5:2], rsv_hi_reg, lh_reg[9:6], rsv_lo_reg};

   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_reg_rdata <= 16'h0000;
      end else if (page_rd) begin
         o_reg_rdata <= {1'b0, sel_reg, page_data};
      end else if (seed_rd) begin
         o_reg_rdata <= shadow_reg ? stat_word : seed_word;
      end else if (i_reg_rd) begin
         o_reg_rdata <= 16'h0000;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_reg_rvalid <= 1'b0;
      end else begin
         o_reg_rvalid <= i_reg_rd;
      end
   end

   // ----------------------------------------
   // Control outputs
   // ----------------------------------------
   logic [2:0] retry_code;
   assign retry_code = spare_reg[cpsr_pkg::RETRY_LSB +: 3];

   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_downgrade_attempts <= cpsr_pkg::RETRY_OFF;
      end else if (i_downgrade_enable) begin
         o_downgrade_attempts <= {1'b0, retry_code} + cpsr_pkg::RETRY_BASE;
      end else begin
         o_downgrade_attempts <= cpsr_pkg::RETRY_OFF;
      end
   end

   // LED selector must also be set to interrupt mode by software
   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_interrupt_output_pin <= 1'b0;
      end else begin
         o_interrupt_output_pin <= spare_reg[cpsr_pkg::ED_BIT] ? i_energy_detect : i_irq_request;
      end
   end

   // ----------------------------------------
   // Auto power-down timers
   // ----------------------------------------
   cpsr_pkg::cpsr_apd_e apd_state;
   logic [cpsr_pkg::TMR_W-1:0] tmr_reg;
   logic apd_en;
   logic [cpsr_pkg::TMR_W-1:0] sleep_len;
   logic [cpsr_pkg::TMR_W-1:0] wake_len;

   assign apd_en = apd_reg[cpsr_pkg::APD_EN_BIT];
   assign sleep_len = apd_reg[cpsr_pkg::SLEEP_SEL_BIT] ? cpsr_pkg::TMR_W'(SLEEP_LONG_CYC)
                                                      : cpsr_pkg::TMR_W'(SLEEP_SHORT_CYC);
   assign wake_len = cpsr_pkg::TMR_W'(longint'(apd_reg[cpsr_pkg::WAKE_LSB +: 4]) * WAKE_UNIT_CYC);

   // Energy on the wire always returns the port to normal operation
   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         apd_state <= cpsr_pkg::CPSR_ACTIVE;
         tmr_reg <= '0;
      end else if (!apd_en || i_energy_detect) begin
         apd_state <= cpsr_pkg::CPSR_ACTIVE;
         tmr_reg <= '0;
      end else begin
         case (apd_state)
            cpsr_pkg::CPSR_ACTIVE: begin
               apd_state <= cpsr_pkg::CPSR_SLEEP;
               tmr_reg <= sleep_len;
            end
            cpsr_pkg::CPSR_SLEEP: begin
               if (tmr_reg <= cpsr_pkg::TMR_W'(1)) begin
                  apd_state <= cpsr_pkg::CPSR_WAKE;
                  tmr_reg <= wake_len;
               end else begin
                  tmr_reg <= tmr_reg - cpsr_pkg::TMR_W'(1);
               end
            end
            cpsr_pkg::CPSR_WAKE: begin
               if (tmr_reg <= cpsr_pkg::TMR_W'(1)) begin
                  apd_state <= cpsr_pkg::CPSR_SLEEP;
                  tmr_reg <= sleep_len;
               end else begin
                  tmr_reg <= tmr_reg - cpsr_pkg::TMR_W'(1);
               end
            end
            default: begin
               apd_state <= cpsr_pkg::CPSR_ACTIVE;
               tmr_reg <= '0;
            end
         endcase
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_apd_sleep <= 1'b0;
         o_apd_wake <= 1'b0;
      end else begin
         o_apd_sleep <= (apd_state == cpsr_pkg::CPSR_SLEEP);
         o_apd_wake <= (apd_state == cpsr_pkg::CPSR_WAKE);
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   sequence seq_page_write;
      page_wr && i_reg_wdata[cpsr_pkg::WE_BIT];
   endsequence
   sequence seq_page_read;
      page_rd ##1 o_reg_rvalid;
   endsequence

   AST_SEL_WRITE: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      page_wr |=> sel_reg == $past(wr_sel))
      else $error("page selector not taken from write");
   AST_NO_WE: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      page_wr && !i_reg_wdata[cpsr_pkg::WE_BIT] |=> $stable(spare_reg) && $stable(apd_reg))
      else $error("page data changed without write enable");
   AST_WE_SPARE: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      seq_page_write and (wr_sel == cpsr_pkg::PAGE_SPARE) |=> spare_reg == $past(i_reg_wdata[9:0]))
      else $error("spare page not written");
   AST_WE_APD: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      seq_page_write and (wr_sel == cpsr_pkg::PAGE_APD) |=> apd_reg == $past(i_reg_wdata[9:0]))
      else $error("power-down page not written");
   AST_PAGE_READ: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      seq_page_read |-> o_reg_rdata[14:10] == $past(sel_reg) && o_reg_rdata[9:0] == $past(page_data))
      else $error("page read returned wrong page");
   AST_RETRY: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      ##1 o_downgrade_attempts == ($past(i_downgrade_enable) ? 4'($past(retry_code)) + 4'd2 : 4'd0))
      else $error("retry attempts wrong");
   AST_ED_ROUTE: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      spare_reg[cpsr_pkg::ED_BIT] && i_energy_detect |=> o_interrupt_output_pin)
      else $error("energy detect not on interrupt pin");
   AST_APD_OFF: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      !apd_en |=> ##1 !o_apd_sleep && !o_apd_wake)
      else $error("power-down active while disabled");
   AST_SHADOW: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      seed_rd |=> o_reg_rdata[15] == $past(shadow_reg) &&
                  o_reg_rdata == ($past(shadow_reg) ? $past(stat_word) : $past(seed_word)))
      else $error("seed address returned wrong register");
   AST_LH_HOLD: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      lh_reg[1] && !seed_rd && !i_an_clear |=> lh_reg[1])
      else $error("latched bit dropped without read");
   AST_LH_CLEAR: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      (stat_rd || i_an_clear) && !i_downgrade_event && !i_mode_result_valid && !i_mode_result_no_link
      |=> lh_reg[9:1] == '0)
      else $error("status bits not cleared");
endmodule : cpsr_regs

// ===== dv/cpsr_mgmt_station.sv
// Management station model: issues strobe-port writes and reads.
// Assumes a free-running clock and a registered, one-cycle read answer.
`timescale 1ns/100ps
module cpsr_mgmt_station (
   input wire logic i_ref_clk,
   input wire logic [15:0] i_reg_rdata,
   input wire logic i_reg_rvalid,
   output logic [15:0] o_reg_addr,
   output logic [15:0] o_reg_wdata,
   output logic o_reg_wr,
   output logic o_reg_rd
);
   initial begin
      o_reg_addr = 16'h0000;
      o_reg_wdata = 16'h0000;
      o_reg_wr = 1'b0;
      o_reg_rd = 1'b0;
   end

   // Idle bus after a write shows inverted address and data so a stale word can never pass
   task automatic write_reg(input logic [15:0] addr, input logic [15:0] data);
      @(posedge i_ref_clk);
      #1;
      o_reg_addr = addr;
      o_reg_wdata = data;
      o_reg_wr = 1'b1;
      @(posedge i_ref_clk);
      #1;
      o_reg_wr = 1'b0;
      o_reg_addr = ~addr;
      o_reg_wdata = ~data;
   endtask : write_reg

   task automatic read_reg(input logic [15:0] addr, output logic [15:0] data);
      int n = 0;
      @(posedge i_ref_clk);
      #1;
      o_reg_addr = addr;
      o_reg_rd = 1'b1;
      @(posedge i_ref_clk);
      #1;
      o_reg_rd = 1'b0;
      o_reg_addr = ~addr;
      while (i_reg_rvalid !== 1'b1 && n < 4) begin
         @(posedge i_ref_clk);
         #1;
         n++;
      end
      data = (i_reg_rvalid === 1'b1) ? i_reg_rdata : 16'hxxxx;
   endtask : read_reg

   task automatic read_page(input logic [4:0] code, output logic [15:0] data);
      write_reg(cpsr_pkg::ADDR_PAGE, {1'b0, code, 10'h000});
      read_reg(cpsr_pkg::ADDR_PAGE, data);
   endtask : read_page

   // Other bits of the page, reserved ones too, are written back unchanged
   task automatic rmw_page(input logic [4:0] code, input logic [9:0] mask, input logic [9:0] val);
      logic [15:0] old;
      read_page(code, old);
      write_reg(cpsr_pkg::ADDR_PAGE, {1'b1, code, (old[9:0] & ~mask) | (val & mask)});
   endtask : rmw_page
endmodule : cpsr_mgmt_station

// ===== dv/tb_top.sv
// Self-checking bench for the copper shadow/status register group.
// Assumes short timer parameters; the station model drives the register port.
`timescale 1ns/100ps
module tb_top;
   logic clk, rstn, wr, rd, rvalid;
   logic [15:0] addr, wdata, rdata;
   logic dg_en, energy, irq, seed_vld, seed_match, p_rep, p_mas, p_man;
   logic gig_off, tx_off, dg_ev, res_vld, res_nl, an_clr, int_pin, apd_sleep, apd_wake;
   logic [10:0] seed;
   logic [1:0] mode;
   logic [3:0] attempts;
   int errors, n_compared;

   always #5 clk = ~clk;

   cpsr_regs #(.WAKE_UNIT_CYC(4), .SLEEP_SHORT_CYC(20), .SLEEP_LONG_CYC(40)) i_dut (
      .i_ref_clk(clk), .i_rstn(rstn), .i_reg_addr(addr), .i_reg_wdata(wdata),
      .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid),
      .i_downgrade_enable(dg_en), .i_energy_detect(energy), .i_irq_request(irq),
      .i_local_seed(seed), .i_local_seed_valid(seed_vld), .i_seed_match(seed_match),
      .i_partner_repeater(p_rep), .i_partner_master(p_mas), .i_partner_manual_en(p_man),
      .i_gig_adv_off(gig_off), .i_tx100_adv_off(tx_off), .i_downgrade_event(dg_ev),
      .i_mode_result_valid(res_vld), .i_mode_result_no_link(res_nl), .i_negotiated_mode_result(mode),
      .i_an_clear(an_clr), .o_downgrade_attempts(attempts), .o_interrupt_output_pin(int_pin),
      .o_apd_sleep(apd_sleep), .o_apd_wake(apd_wake));

   cpsr_mgmt_station i_mgmt (.i_ref_clk(clk), .i_reg_rdata(rdata), .i_reg_rvalid(rvalid),
      .o_reg_addr(addr), .o_reg_wdata(wdata), .o_reg_wr(wr), .o_reg_rd(rd));

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick

   task automatic pulse(ref logic s);
      s = 1'b1;
      tick(1);
      s = 1'b0;
   endtask : pulse

   // Length of the next high phase of sleep or wake, bounded both ways
   task automatic measure(input bit pick_wake, output int n);
      int w = 0;
      n = 0;
      while ((pick_wake ? apd_wake : apd_sleep) !== 1'b1 && w < 200) begin
         tick(1);
         w++;
      end
      while ((pick_wake ? apd_wake : apd_sleep) === 1'b1 && n < 200) begin
         tick(1);
         n++;
      end
   endtask : measure

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_reset;
      logic [15:0] d;
      i_mgmt.read_reg(cpsr_pkg::ADDR_PAGE, d);
      check(d, {1'b0, cpsr_pkg::PAGE_SPARE, 10'h000});
      i_mgmt.read_page(cpsr_pkg::PAGE_APD, d);
      check(d, {1'b0, cpsr_pkg::PAGE_APD, 10'h001});
      i_mgmt.read_reg(cpsr_pkg::ADDR_SEED, d);
      check(d, 16'h0000);
      i_mgmt.read_reg(16'hfffe, d);
      check(d, 16'h0000);
      check({11'h000, attempts, int_pin}, 16'h0000);
      // Unassigned page code selects nothing and reads back zero data
      i_mgmt.read_page(5'h1f, d);
      check(d, 16'h7c00);
   endtask : t_reset

   task automatic t_write_enable;
      logic [15:0] d;
      i_mgmt.write_reg(cpsr_pkg::ADDR_PAGE, {1'b0, cpsr_pkg::PAGE_SPARE, 10'h3ff});
      i_mgmt.read_reg(cpsr_pkg::ADDR_PAGE, d);
      check(d, {1'b0, cpsr_pkg::PAGE_SPARE, 10'h000});
      i_mgmt.rmw_page(cpsr_pkg::PAGE_SPARE, 10'h002, 10'h002);
      i_mgmt.read_page(cpsr_pkg::PAGE_SPARE, d);
      check(d, {1'b0, cpsr_pkg::PAGE_SPARE, 10'h002});
      i_mgmt.read_page(cpsr_pkg::PAGE_APD, d);
      check(d, {1'b0, cpsr_pkg::PAGE_APD, 10'h001});
   endtask : t_write_enable

   task automatic t_retry;
      dg_en = 1'b1;
      for (int c = 0; c < 8; c++) begin
         i_mgmt.rmw_page(cpsr_pkg::PAGE_SPARE, 10'h01c, 10'(c << 2));
         tick(2);
         check({12'h000, attempts}, 16'(c + 2));
      end
      dg_en = 1'b0;
      tick(2);
      check({12'h000, attempts}, 16'h0000);
   endtask : t_retry

   task automatic t_irq_route;
      for (int b = 0; b < 2; b++) begin
         i_mgmt.rmw_page(cpsr_pkg::PAGE_SPARE, 10'h002, 10'(b << 1));
         energy = 1'b1;
         irq = 1'b0;
         tick(2);
         check({15'h0000, int_pin}, 16'(b));
         energy = 1'b0;
         irq = 1'b1;
         tick(2);
         check({15'h0000, int_pin}, 16'(1 - b));
         irq = 1'b0;
      end
   endtask : t_irq_route

   task automatic t_apd;
      int n;
      logic [3:0] w;
      for (int s = 0; s < 2; s++) begin
         w = s ? 4'hf : 4'h2;
         i_mgmt.rmw_page(cpsr_pkg::PAGE_APD, 10'h03f, {4'h0, 1'b1, s[0], w});
         measure(1'b0, n);
         check(16'(n), s ? 16'h0028 : 16'h0014);
         measure(1'b1, n);
         check(16'(n), {10'h000, w, 2'b00});
         energy = 1'b1;
         tick(3);
         check({14'h0000, apd_sleep, apd_wake}, 16'h0000);
         i_mgmt.rmw_page(cpsr_pkg::PAGE_APD, 10'h020, 10'h000);
         energy = 1'b0;
         tick(3);
         check({14'h0000, apd_sleep, apd_wake}, 16'h0000);
      end
   endtask : t_apd

   task automatic t_seed;
      logic [15:0] d;
      seed = 11'h5a5;
      pulse(seed_vld);
      pulse(seed_match);
      {p_rep, p_mas, p_man} = 3'b101;
      i_mgmt.read_reg(cpsr_pkg::ADDR_SEED, d);
      check(d, 16'h6da5);
      i_mgmt.read_reg(cpsr_pkg::ADDR_SEED, d);
      check(d, 16'h2da5);
      i_mgmt.write_reg(cpsr_pkg::ADDR_SEED, 16'h0123);
      {p_rep, p_mas, p_man} = 3'b011;
      i_mgmt.read_reg(cpsr_pkg::ADDR_SEED, d);
      check(d, 16'h1923);
   endtask : t_seed

   task automatic t_status;
      logic [15:0] d;
      i_mgmt.write_reg(cpsr_pkg::ADDR_SEED, 16'h8000);
      {gig_off, tx_off} = 2'b10;
      i_mgmt.read_reg(cpsr_pkg::ADDR_SEED, d);
      check(d & 16'hff3c, 16'hc000);
      {gig_off, tx_off} = 2'b01;
      // Reserved bits 7:6 and 1:0 are masked, their content is not defined
      for (int m = 0; m < 4; m++) begin
         mode = 2'(m);
         pulse(res_vld);
         i_mgmt.read_reg(cpsr_pkg::ADDR_SEED, d);
         check(d & 16'hff3c, 16'ha000 | (16'h0100 << m));
         pulse(res_nl);
         i_mgmt.read_reg(cpsr_pkg::ADDR_SEED, d);
         check(d & 16'hff3c, 16'ha000 | (16'h0004 << m));
      end
      pulse(dg_ev);
      i_mgmt.read_reg(cpsr_pkg::ADDR_SEED, d);
      check(d & 16'hff3c, 16'hb000);
      pulse(dg_ev);
      mode = 2'b11;
      pulse(res_vld);
      pulse(an_clr);
      i_mgmt.read_reg(cpsr_pkg::ADDR_SEED, d);
      check(d & 16'hff3c, 16'ha000);
   endtask : t_status

   // ----------------------------------------
   // Run control
   // ----------------------------------------
   task automatic give_verdict;
      $display("Comparisons %0d, errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : give_verdict

   initial begin
      clk = 1'b0;
      rstn = 1'b0;
      {dg_en, energy, irq, seed_vld, seed_match, p_rep, p_mas, p_man} = 8'h00;
      {gig_off, tx_off, dg_ev, res_vld, res_nl, an_clr} = 6'h00;
      seed = 11'h000;
      mode = 2'b00;
      errors = 0;
      n_compared = 0;
      repeat (3) @(posedge clk);
      #1;
      rstn = 1'b1;
      t_reset;
      t_write_enable;
      t_retry;
      t_irq_route;
      t_apd;
      t_seed;
      t_status;
      give_verdict;
   end

   // Whole run is a few hundred cycles; this is a wide margin
   initial begin
      #200000;
      errors++;
      give_verdict;
   end
endmodule : tb_top
